// >>> hdl/piet_pkg.sv
// Package for the priority interrupt and event transfer block.
// Assumes one clock (mclk, 100 MHz) and an APB register port.
package piet_pkg;

   // ***
   // Sizes
   // ***
   localparam int NODES      = 16;            // Interrupt nodes
   localparam int NODE_W     = 4;             // Node index width
   localparam int PRIO_W     = 4;             // Sixteen priority levels
   localparam int CHANS      = 8;             // Event transfer channels
   localparam int CHAN_W     = 3;             // Channel index width
   localparam int TRAP_W     = 7;             // Trap number width

   // ***
   // Node control word layout
   // ***
   localparam int NC_PRIO_LSB  = 0;           // Priority field bits 3:0
   localparam int NC_CHAN_LSB  = 4;           // Channel field bits 6:4
   localparam int NC_ROUTE_BIT = 7;           // 1 = event transfer route
   localparam int NC_EN_BIT    = 8;           // Enable flag
   localparam int NC_REQ_BIT   = 9;           // Request flag

   // ***
   // Channel control word layout
   // ***
   localparam int CC_CNT_LSB   = 0;           // Counter bits 7:0
   localparam int CC_CNT_W     = 8;           // Counter width
   localparam int CC_WORD_BIT  = 8;           // 1 = word transfer
   localparam int CC_SINC_BIT  = 9;           // Increment source
   localparam int CC_DINC_BIT  = 10;          // Increment destination
   localparam int CC_CONT_BIT  = 11;          // Continuous mode

   // ***
   // Register map (byte addresses)
   // ***
   localparam logic [11:0] A_NODE   = 12'h000; // Node ctl, 16 words
   localparam logic [11:0] A_CCTL   = 12'h040; // Channel ctl, 8 words
   localparam logic [11:0] A_SRC    = 12'h060; // Source ptr, 8 words
   localparam logic [11:0] A_DST    = 12'h080; // Dest ptr, 8 words
   localparam logic [11:0] A_STAT   = 12'h0A0; // Sticky event status
   localparam logic [11:0] A_MASK   = 12'h0A4; // Interrupt mask
   localparam logic [11:0] A_EXTCFG = 12'h0A8; // Edge select, 2 bits/pin
   localparam logic [11:0] A_CORE   = 12'h0AC; // Running level (read)

   // ***
   // Edge modes and status bits
   // ***
   localparam logic [1:0] EDGE_RISE = 2'h1;   // Rising only
   localparam logic [1:0] EDGE_FALL = 2'h2;   // Falling only
   localparam logic [1:0] EDGE_BOTH = 2'h3;   // Both edges
   localparam int ST_VEC  = 0;                // Vector taken
   localparam int ST_XFER = 1;                // Transfer done
   localparam int ST_EOC  = 2;                // Counter reached zero

   // ***
   // Timing
   // ***
   localparam int CLK_MHZ      = 100;          // mclk rate
   localparam int RESP_CYCLES  = 8;            // Typical response, cycles

   // ***
   // Types
   // ***
   typedef enum logic [1:0] {
      S_IDLE = 2'h0,                           // Waiting
      S_ARB  = 2'h1,                           // Winner latched
      S_XFER = 2'h3,                           // Bus cycle stolen
      S_VEC  = 2'h2                            // Vector issued
   } piet_state_type;

   typedef struct packed {
      logic        valid;                      // Transfer request
      logic        word;                       // Word size
      logic [23:0] src;                        // Source address
      logic [23:0] dst;                        // Destination address
   } piet_xfer_type;

endpackage

// >>> hdl/piet_top.sv
// Interrupt arbiter, vectoring and eight-channel event transfer engine.
// Assumes a core that acks vectors and grants stolen bus cycles.
// Functional notes
// - Each node has request, enable, priority
// - Sixteen priority levels per node
// - Preempt service only for higher priority
// - Each node has distinct vector location
// - Standard service redirects core to vector
// - Respond within eight clocks typically
// - Software routes node to controller or engine
// - Event transfer steals one cycle only
// - Move byte/word, increment pointers as configured
// - Decrement counter unless continuous mode
// - Counter zero raises node's standard interrupt (here the forced vector goes to whichever node wins arbitration next)
// - Eight channels with own pointers, counters
// - Fast inputs detect rise, fall, both
// - Trap number enters matching service
// - Software-set request acts like hardware
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module piet_top #(
   parameter logic [23:0] VEC_BASE = 24'h000040, // Vector table base
   parameter int          EXT_PINS = 4           // Fast external inputs
) (
   input  wire logic                              mclk,        // Clock
   input  wire logic                              reset,       // Async reset
   input  wire logic [11:0]                       paddr,       // APB address
   input  wire logic                              psel,        // APB select
   input  wire logic                              penable,     // APB enable
   input  wire logic                              pwrite,      // APB write
   input  wire logic [31:0]                       pwdata,      // APB wdata
   output logic      [31:0]                       prdata,      // APB rdata
   output logic                                   pready,      // APB ready
   output logic                                   pslverr,     // APB error
   input  wire logic [piet_pkg::NODES-1:0]        periph_req,  // Source pulses
   input  wire logic [EXT_PINS-1:0]               ext_pin,     // Fast inputs
   input  wire logic                              trap_valid,  // Trap pulse
   input  wire logic [piet_pkg::TRAP_W-1:0]       trap_num,    // Trap number
   output logic                                   vec_req,     // Vector request
   output logic      [23:0]                       vec_addr,    // Vector address
   output logic      [piet_pkg::PRIO_W-1:0]       vec_level,   // Service level
   input  wire logic                              vec_ack,     // Core accepted
   input  wire logic                              svc_return,  // Service ended
   output logic                                   xfer_req,    // Steal request
   output piet_pkg::piet_xfer_type                xfer,        // Transfer info
   input  wire logic                              xfer_grant,  // Cycle granted
   output logic                                   irq          // Status irq
);

   // ***
   // Declarations
   // ***
   localparam int N = piet_pkg::NODES; // Node count
   localparam int C = piet_pkg::CHANS; // Channel count
   logic [9:0]  node_r [N]; // Node control words
   logic [11:0] cctl_r [C]; // Channel control words
   logic [23:0] src_r  [C]; // Source pointers
   logic [23:0] dst_r  [C]; // Destination pointers
   logic [2:0]  stat_r; // Sticky status
   logic [2:0]  mask_r; // Status mask
   logic [2*EXT_PINS-1:0] edge_cfg_r; // Edge selects
   logic [EXT_PINS-1:0] ext_s1_r; // Sync stage 1
   logic [EXT_PINS-1:0] ext_s2_r; // Sync stage 2
   logic [EXT_PINS-1:0] ext_d_r; // Previous level
   logic [EXT_PINS-1:0] ext_hit; // Edge detected
   logic [N-1:0] hw_set; // Per node hardware set
   logic [4:0]  run_level_r; // Running level, 16 = none
   logic [4:0]  stack_r [N]; // Saved levels
   logic [3:0]  sp_r; // Stack depth
   piet_pkg::piet_state_type st_r; // Engine state
   logic [3:0]  win_node_r; // Latched winner
   logic        win_found; // Arbiter hit
   logic [3:0]  win_node; // Arbiter result
   logic [3:0]  win_prio; // Winner level
   logic        force_vec_r; // Counter reached zero
   logic        wr_en; // APB write strobe
   logic        rd_en; // APB read strobe
   logic [2:0]  wch; // Winner channel
   logic [11:0] wcc; // Winner channel word
   logic        accept; // Request accepted

   // ***
   // APB slave
   // ***
   assign pready  = 1'b1;                      // Zero wait states
   assign pslverr = 1'b0;                      // Unmapped reads zero
   assign wr_en   = psel & penable & pwrite;   // Write at access edge
   assign rd_en   = psel & ~pwrite;            // Read data during setup

   // Read mux registered from setup phase
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         prdata <= 32'h00000000;
      end
      else if (rd_en && !penable)
      begin
         prdata <= 32'h00000000;               // Default for unmapped
         if (paddr < piet_pkg::A_CCTL)
            prdata <= {22'h000000, node_r[paddr[5:2]]};
         else if (paddr < piet_pkg::A_SRC)
            prdata <= {20'h00000, cctl_r[paddr[4:2]]};
         else if (paddr < piet_pkg::A_DST)
            prdata <= {8'h00, src_r[paddr[4:2]]};
         else if (paddr < piet_pkg::A_STAT)
            prdata <= {8'h00, dst_r[paddr[4:2]]};
         else if (paddr == piet_pkg::A_STAT)
            prdata <= {29'h00000000, stat_r};
         else if (paddr == piet_pkg::A_MASK)
            prdata <= {29'h00000000, mask_r};
         else if (paddr == piet_pkg::A_EXTCFG)
            prdata <= 32'(edge_cfg_r);
         else if (paddr == piet_pkg::A_CORE)
            prdata <= {27'h0000000, run_level_r};
      end
   end

   // ***
   // Fast external inputs
   // ***
   // Two-stage synchroniser, then edge compare
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ext_s1_r <= '0;
         ext_s2_r <= '0;
         ext_d_r  <= '0;
      end
      else
      begin
         ext_s1_r <= ext_pin;
         ext_s2_r <= ext_s1_r;
         ext_d_r  <= ext_s2_r;
      end
   end

   // Edge type per pin
   genvar gi;
   generate
      for (gi = 0; gi < EXT_PINS; gi++)
      begin : g_edge
         assign ext_hit[gi] =
            (edge_cfg_r[2*gi+:2] == piet_pkg::EDGE_RISE &&  ext_s2_r[gi] && !ext_d_r[gi]) ||
            (edge_cfg_r[2*gi+:2] == piet_pkg::EDGE_FALL && !ext_s2_r[gi] &&  ext_d_r[gi]) ||
            (edge_cfg_r[2*gi+:2] == piet_pkg::EDGE_BOTH && (ext_s2_r[gi] != ext_d_r[gi]));
      end
   endgenerate

   // Hardware sets: peripherals, fast pins on top nodes, traps
   always_comb
   begin
      hw_set = periph_req;
      for (int i = 0; i < EXT_PINS; i++)
         hw_set[N-EXT_PINS+i] = hw_set[N-EXT_PINS+i] | ext_hit[i];
      if (trap_valid && trap_num < 7'(N))
         hw_set[trap_num[3:0]] = 1'b1;
   end

   // ***
   // Arbiter
   // ***
   // Highest level wins; ties go to lowest node
   always_comb
   begin
      win_found = 1'b0;
      win_node  = 4'h0;
      win_prio  = 4'h0;
      for (int i = 0; i < N; i++)
      begin
         if (node_r[i][piet_pkg::NC_REQ_BIT] && node_r[i][piet_pkg::NC_EN_BIT] &&
             (run_level_r == 5'h10 || 5'(node_r[i][3:0]) > run_level_r) &&
             (!win_found || node_r[i][3:0] > win_prio))
         begin
            win_found = 1'b1;
            win_node  = 4'(i);
            win_prio  = node_r[i][3:0];
         end
      end
   end

   assign wch    = node_r[win_node_r][6:4];
   assign wcc    = cctl_r[wch];
   assign accept = (st_r == piet_pkg::S_VEC && vec_ack) ||
                   (st_r == piet_pkg::S_XFER && xfer_grant);

   // ***
   // Service sequencer
   // ***
   // Latch winner, then vector or steal one cycle
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         st_r        <= piet_pkg::S_IDLE;
         win_node_r  <= 4'h0;
         force_vec_r <= 1'b0;
      end
      else
      begin
         case (st_r)
            piet_pkg::S_IDLE:
               if (win_found)
               begin
                  win_node_r <= win_node;
                  st_r       <= piet_pkg::S_ARB;
               end
            piet_pkg::S_ARB:
               if (node_r[win_node_r][piet_pkg::NC_ROUTE_BIT] && !force_vec_r)
                  st_r <= piet_pkg::S_XFER;
               else
                  st_r <= piet_pkg::S_VEC;
            piet_pkg::S_XFER:
               if (xfer_grant)
               begin
                  st_r <= piet_pkg::S_IDLE;
                  if (!wcc[piet_pkg::CC_CONT_BIT] && wcc[7:0] == 8'h01)
                     force_vec_r <= 1'b1;
               end
            piet_pkg::S_VEC:
               if (vec_ack)
               begin
                  st_r        <= piet_pkg::S_IDLE;
                  force_vec_r <= 1'b0;
               end
            default:
               st_r <= piet_pkg::S_IDLE;
         endcase
      end
   end

   // Core-facing outputs from registers
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         vec_req   <= 1'b0;
         vec_addr  <= 24'h000000;
         vec_level <= 4'h0;
         xfer_req  <= 1'b0;
         xfer      <= '0;
      end
      else
      begin
         vec_req   <= (st_r == piet_pkg::S_ARB) &&
                      !(node_r[win_node_r][piet_pkg::NC_ROUTE_BIT] && !force_vec_r) ||
                      (st_r == piet_pkg::S_VEC && !vec_ack);
         vec_addr  <= VEC_BASE + {18'h00000, win_node_r, 2'b00};
         vec_level <= node_r[win_node_r][3:0];
         xfer_req  <= (st_r == piet_pkg::S_ARB) &&
                      node_r[win_node_r][piet_pkg::NC_ROUTE_BIT] && !force_vec_r ||
                      (st_r == piet_pkg::S_XFER && !xfer_grant);
         xfer.valid <= (st_r == piet_pkg::S_ARB) && !force_vec_r &&
                       node_r[win_node_r][piet_pkg::NC_ROUTE_BIT] ||
                       (st_r == piet_pkg::S_XFER && !xfer_grant);
         xfer.word  <= wcc[piet_pkg::CC_WORD_BIT];
         xfer.src   <= src_r[wch];
         xfer.dst   <= dst_r[wch];
      end
   end

   // ***
   // Running level stack
   // ***
   // Push on vector accept, pop on return
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         run_level_r <= 5'h10;
         sp_r        <= 4'h0;
         for (int i = 0; i < N; i++)
            stack_r[i] <= 5'h10;
      end
      else if (st_r == piet_pkg::S_VEC && vec_ack)
      begin
         stack_r[sp_r] <= run_level_r;
         sp_r          <= sp_r + 4'h1;
         run_level_r   <= {1'b0, node_r[win_node_r][3:0]};
      end
      else if (svc_return && sp_r != 4'h0)
      begin
         sp_r        <= sp_r - 4'h1;
         run_level_r <= stack_r[sp_r - 4'h1];
      end
   end

   // ***
   // Node control registers
   // ***
   // Set beats software clear; accept clears, except a transfer that empties its counter
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < N; i++)
            node_r[i] <= 10'h000;
      end
      else
      begin
         for (int i = 0; i < N; i++)
         begin
            if (wr_en && paddr < piet_pkg::A_CCTL && paddr[5:2] == 4'(i))
               node_r[i] <= pwdata[9:0];
            if (accept && win_node_r == 4'(i) &&
                !(st_r == piet_pkg::S_XFER && force_vec_r == 1'b0 &&
                  !wcc[piet_pkg::CC_CONT_BIT] && wcc[7:0] == 8'h01))
               node_r[i][piet_pkg::NC_REQ_BIT] <= 1'b0;
            if (hw_set[i])
               node_r[i][piet_pkg::NC_REQ_BIT] <= 1'b1;
         end
      end
   end

   // ***
   // Channel registers
   // ***
   // Software writes, then per-transfer updates
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < C; i++)
         begin
            cctl_r[i] <= 12'h000;
            src_r[i]  <= 24'h000000;
            dst_r[i]  <= 24'h000000;
         end
      end
      else
      begin
         for (int i = 0; i < C; i++)
         begin
            if (wr_en && paddr[11:5] == piet_pkg::A_CCTL[11:5] && paddr[4:2] == 3'(i))
               cctl_r[i] <= pwdata[11:0];
            if (wr_en && paddr[11:5] == piet_pkg::A_SRC[11:5] && paddr[4:2] == 3'(i))
               src_r[i] <= pwdata[23:0];
            if (wr_en && paddr[11:5] == piet_pkg::A_DST[11:5] && paddr[4:2] == 3'(i))
               dst_r[i] <= pwdata[23:0];
            if (st_r == piet_pkg::S_XFER && xfer_grant && wch == 3'(i))
            begin
               if (wcc[piet_pkg::CC_SINC_BIT])
                  src_r[i] <= src_r[i] + (wcc[piet_pkg::CC_WORD_BIT] ? 24'h2 : 24'h1);
               if (wcc[piet_pkg::CC_DINC_BIT])
                  dst_r[i] <= dst_r[i] + (wcc[piet_pkg::CC_WORD_BIT] ? 24'h2 : 24'h1);
               if (!wcc[piet_pkg::CC_CONT_BIT] && wcc[7:0] != 8'h00)
                  cctl_r[i][7:0] <= wcc[7:0] - 8'h01;
            end
         end
      end
   end

   // ***
   // Status, mask and edge config
   // ***
   // Hardware set wins over write-one clear
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         stat_r     <= 3'h0;
         mask_r     <= 3'h0;
         edge_cfg_r <= '0;
      end
      else
      begin
         if (wr_en && paddr == piet_pkg::A_MASK)
            mask_r <= pwdata[2:0];
         if (wr_en && paddr == piet_pkg::A_EXTCFG)
            edge_cfg_r <= pwdata[2*EXT_PINS-1:0];
         stat_r <= (stat_r & ~((wr_en && paddr == piet_pkg::A_STAT) ? pwdata[2:0] : 3'h0)) |
                   {force_vec_r && st_r == piet_pkg::S_VEC && vec_ack,
                    st_r == piet_pkg::S_XFER && xfer_grant,
                    st_r == piet_pkg::S_VEC && vec_ack};
      end
   end

   // Level interrupt from unmasked status
   assign irq = |(stat_r & mask_r);

endmodule

// >>> test/piet_asserts.sv
// Checker on the piet_top ports.
// Assumes it is bound into every piet_top instance.
`timescale 1ns/1ps
module piet_asserts #(
   parameter logic [23:0] VEC_BASE = 24'h000040 // Vector base
) (
   input wire logic                    mclk,       // Clock
   input wire logic                    reset,      // Reset
   input wire logic                    psel,       // APB select
   input wire logic                    penable,    // APB enable
   input wire logic                    pready,     // APB ready
   input wire logic                    pslverr,    // APB error
   input wire logic                    vec_req,    // Vector request
   input wire logic [23:0]             vec_addr,   // Vector address
   input wire logic                    vec_ack,    // Core accept
   input wire logic                    xfer_req,   // Steal request
   input wire piet_pkg::piet_xfer_type xfer,       // Transfer info
   input wire logic                    xfer_grant, // Cycle granted
   input wire logic                    irq         // Status irq
);
   // ***
   // Assertions
   // ***
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   vec_hold_a: assert property (vec_req && !vec_ack |=> vec_req && $stable(vec_addr))
      else $error("vector request not held");
   vec_drop_a: assert property (vec_req && vec_ack |=> !vec_req)
      else $error("vector request kept after accept");
   vec_place_a: assert property (vec_req |-> vec_addr[1:0] == 2'h0 && vec_addr >= VEC_BASE
      && vec_addr < VEC_BASE + 24'h000040) else $error("vector outside table");
   one_service_a: assert property (!(vec_req && xfer_req))
      else $error("vector and transfer together");
   steal_once_a: assert property (xfer_req && xfer_grant |=> !xfer_req)
      else $error("more than one stolen cycle");
   xfer_hold_a: assert property (xfer_req && !xfer_grant |=> xfer_req && $stable(xfer))
      else $error("transfer request not held");
   xfer_valid_a: assert property (xfer_req |-> xfer.valid)
      else $error("transfer without valid");
   apb_ready_a: assert property (psel && penable |-> pready && !pslverr)
      else $error("access not answered");
   // Main scenarios reached
   vec_c: cover property (vec_req && vec_ack);
   xfer_c: cover property (xfer_req && xfer_grant);
   irq_c: cover property ($rose(irq));
endmodule
bind piet_top piet_asserts #(.VEC_BASE(VEC_BASE)) chk (.mclk(mclk), .reset(reset), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .vec_req(vec_req),
   .vec_addr(vec_addr), .vec_ack(vec_ack), .xfer_req(xfer_req), .xfer(xfer),
   .xfer_grant(xfer_grant), .irq(irq));

// >>> test/piet_core_model.sv
// Core model: accepts vectors, grants stolen cycles after dly cycles.
// Assumes requests are held until accepted.
`timescale 1ns/1ps
module piet_core_model (
   input  wire logic       mclk,       // Clock
   input  wire logic       reset,      // Reset
   input  wire logic       vec_req,    // Vector request
   input  wire logic       xfer_req,   // Steal request
   input  wire logic [3:0] dly,        // Answer delay
   output logic            vec_ack,    // Accept pulse
   output logic            xfer_grant  // Grant pulse
);
   logic [3:0] cnt_r; // Wait counter
   // One-cycle answers after the wait
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         cnt_r      <= 4'h0;
         vec_ack    <= 1'b0;
         xfer_grant <= 1'b0;
      end
      else
      begin
         vec_ack    <= vec_req && !vec_ack && cnt_r == dly;
         xfer_grant <= xfer_req && !xfer_grant && cnt_r == dly;
         cnt_r      <= (vec_req && !vec_ack) || (xfer_req && !xfer_grant) ? cnt_r + 4'h1 : 4'h0;
      end
   end
endmodule

// >>> test/piet_top_tb.sv
// Bench for piet_top over APB with the core model.
// Assumes the checker and core model are compiled first.
`timescale 1ns/1ps
module piet_top_tb;
   // ***
   // Signals
   // ***
   localparam logic [23:0] VEC_BASE = 24'h000040; // Vector base
   logic        mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, trap_valid = 0;
   logic        svc_return = 0, vec_req, vec_ack, xfer_req, xfer_grant, irq, pready, pslverr;
   logic [11:0] paddr = 0; // Address
   logic [31:0] pwdata = 0, prdata, rd; // Data
   logic [15:0] periph_req = 0; // Sources
   logic [3:0]  ext_pin = 0, dly = 0, n, p;
   logic [6:0]  trap_num = 0; // Trap number
   logic [1:0]  k; // Source kind
   logic [23:0] vec_addr; // Vector
   logic [3:0]  vec_level; // Level
   piet_pkg::piet_xfer_type xfer; // Transfer
   int          num_errors = 0, compares = 0;
   // Rows: kind (0 source, 1 trap, 2 soft), node, prio, core delay
   logic [13:0] rows [5] = '{{2'h0, 4'h0, 4'h0, 4'h0}, {2'h0, 4'hF, 4'hF, 4'h3},
      {2'h1, 4'h9, 4'h4, 4'h1}, {2'h2, 4'hA, 4'h8, 4'h5}, {2'h1, 4'h1, 4'hC, 4'h2}};
   piet_top #(.VEC_BASE(VEC_BASE), .EXT_PINS(4)) dut (.mclk(mclk), .reset(reset),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
      .ext_pin(ext_pin), .trap_valid(trap_valid), .trap_num(trap_num), .vec_req(vec_req),
      .vec_addr(vec_addr), .vec_level(vec_level), .vec_ack(vec_ack),
      .svc_return(svc_return), .xfer_req(xfer_req), .xfer(xfer), .xfer_grant(xfer_grant),
      .irq(irq));
   piet_core_model core (.mclk(mclk), .reset(reset), .vec_req(vec_req), .xfer_req(xfer_req),
      .dly(dly), .vec_ack(vec_ack), .xfer_grant(xfer_grant));
   initial forever #5 mclk = ~mclk;
   // ***
   // Tasks
   // ***
   function automatic logic [11:0] na(input logic [3:0] x);
      return piet_pkg::A_NODE + 12'(4 * x);
   endfunction
   // One APB transfer, read data into rd
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", s, e, g);
      end
   endtask
   // One-cycle source pulse or trap
   task automatic raise(input logic t, input logic [15:0] m, input logic [3:0] x);
      @(posedge mclk);
      periph_req <= m;
      trap_valid <= t;
      trap_num <= {3'h0, x};
      @(posedge mclk);
      periph_req <= 16'h0000;
      trap_valid <= 0;
   endtask
   task automatic wait_vec(input logic [3:0] x, input logic [3:0] l);
      int c;
      c = 0;
      do begin @(negedge mclk); c++; end while (vec_req !== 1'b1 && c < 40);
      chk("latency", 1, c <= piet_pkg::RESP_CYCLES);
      chk("vec_addr", 32'(VEC_BASE) + 32'(x) * 4, vec_addr);
      chk("vec_level", l, vec_level);
      while (vec_req === 1'b1 && c < 80) begin @(negedge mclk); c++; end
   endtask
   task automatic wait_xfer(input logic [23:0] s, input logic [23:0] d, input logic w);
      int c;
      c = 0;
      do begin @(negedge mclk); c++; end while (xfer_req !== 1'b1 && c < 40);
      chk("xfer_src", s, xfer.src);
      chk("xfer_dst", d, xfer.dst);
      chk("xfer_word", w, xfer.word);
      while (xfer_req === 1'b1 && c < 80) begin @(negedge mclk); c++; end
   endtask
   task automatic ret;
      @(posedge mclk);
      svc_return <= 1;
      @(posedge mclk);
      svc_return <= 0;
   endtask
   task automatic quiet;
      logic seen;
      seen = 0;
      repeat (12) @(negedge mclk) seen |= vec_req;
      chk("no_vector", 0, seen);
   endtask
   task automatic rdchk(input string s, input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(s, e, rd);
   endtask
   task automatic irqchk(input logic [11:0] a, input logic [31:0] d, input logic e);
      apb(1, a, d);
      @(negedge mclk);
      chk("irq", e, irq);
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      #300000;
      num_errors++;
      report_and_stop;
   end
   // ***
   // Tests
   // ***
   initial
   begin
      repeat (4) @(posedge mclk);
      reset <= 0;
      for (int i = 0; i < 5; i++)
      begin
         {k, n, p} = rows[i][13:4];
         dly <= rows[i][3:0];
         apb(1, na(n), 32'h100 | p);
         if (k == 2'h2)
            apb(1, na(n), 32'h300 | p);
         else
            raise(k[0], k == 2'h0 ? 16'h0001 << n : 16'h0000, n);
         wait_vec(n, p);
         rdchk("req_clear", na(n), 32'h100 | p);
         ret;
         apb(1, na(n), 0);
      end
      $display("test table done");
      apb(1, na(2), 32'h105);
      apb(1, na(4), 32'h105);
      apb(1, na(6), 32'h109);
      raise(0, 16'h0004, 0);
      wait_vec(2, 5);
      raise(0, 16'h0010, 0);
      quiet;
      raise(0, 16'h0040, 0);
      wait_vec(6, 9);
      ret;
      quiet;
      ret;
      wait_vec(4, 5);
      ret;
      apb(1, na(3), 32'h107);
      apb(1, na(5), 32'h107);
      raise(0, 16'h0028, 0);
      wait_vec(3, 7);
      ret;
      wait_vec(5, 7);
      ret;
      $display("test preempt done");
      dly <= 4'h3;
      apb(1, piet_pkg::A_CCTL + 12'h004, 32'h702);
      apb(1, piet_pkg::A_SRC + 12'h004, 32'h1000);
      apb(1, piet_pkg::A_DST + 12'h004, 32'h2000);
      apb(1, na(7), 32'h191);
      raise(0, 16'h0080, 0);
      wait_xfer(24'h001000, 24'h002000, 1);
      rdchk("src_inc", piet_pkg::A_SRC + 12'h004, 32'h1002);
      rdchk("count", piet_pkg::A_CCTL + 12'h004, 32'h701);
      raise(0, 16'h0080, 0);
      wait_xfer(24'h001002, 24'h002002, 1);
      wait_vec(7, 1);
      ret;
      irqchk(piet_pkg::A_MASK, 0, 0);
      irqchk(piet_pkg::A_MASK, 4, 1);
      irqchk(piet_pkg::A_STAT, 4, 0);
      apb(1, piet_pkg::A_CCTL + 12'h008, 32'hC01);
      apb(1, piet_pkg::A_SRC + 12'h008, 32'h300);
      apb(1, piet_pkg::A_DST + 12'h008, 32'h400);
      apb(1, na(8), 32'h1A1);
      raise(0, 16'h0100, 0);
      wait_xfer(24'h000300, 24'h000400, 0);
      rdchk("dst_inc", piet_pkg::A_DST + 12'h008, 32'h401);
      rdchk("src_hold", piet_pkg::A_SRC + 12'h008, 32'h300);
      rdchk("count_cont", piet_pkg::A_CCTL + 12'h008, 32'hC01);
      $display("test transfer done");
      apb(1, piet_pkg::A_EXTCFG, 32'h39);
      for (int e = 0; e < 2; e++)
      begin
         ext_pin <= e ? 4'h0 : 4'hF;
         repeat (6) @(posedge mclk);
         for (int i = 0; i < 4; i++)
         begin
            apb(0, na(12 + i), 0);
            chk("edge", (e ? 4'h6 : 4'h5) >> i & 4'h1, rd[9]);
            apb(1, na(12 + i), 0);
         end
      end
      $display("test edges done");
      reset <= 1;
      repeat (4) @(posedge mclk);
      reset <= 0;
      rdchk("node_rst", na(7), 0);
      rdchk("level_rst", piet_pkg::A_CORE, 32'h10);
      rdchk("stat_rst", piet_pkg::A_STAT, 0);
      apb(1, 12'hFF0, 32'hFFFF);
      rdchk("unmapped", 12'hFF0, 0);
      $display("test reset done");
      report_and_stop;
   end
endmodule
